/* inc/cascade_trigger_sync_consts.svh */
// Purpose: named constants of the cascade trigger block
// Assumes: 25 MHz system clock
// Notes: offsets are word indices on the plain register port
`ifndef CASCADE_TRIGGER_SYNC_CONSTS_SVH
`define CASCADE_TRIGGER_SYNC_CONSTS_SVH
`define CLK_HZ 25000000
`define US_CYCLES (`CLK_HZ / 1000000)
`define MS_TO_US 1000
// Register offsets
`define REG_CASCADE 4'h0
`define REG_MASTER_CYCLE 4'h1
`define REG_SLAVE_DELAY 4'h2
`define REG_PIN_CFG 4'h3
`define REG_STATUS 4'h4
`define REG_SCAN_LEN 4'h5
// Field positions in the cascade register
`define FLD_ENABLE 0
`define FLD_ROLE 1
// Field positions in the pin register
`define FLD_DIR 0
`define FLD_POL 1
`define FLD_OUTF_LO 4
`define FLD_INF_LO 8
// Encodings
`define ENABLE_ON 1'b1
`define ROLE_MASTER 1'b1
`define ROLE_SLAVE 1'b0
`define DIR_INPUT 1'b1
`define DIR_OUTPUT 1'b0
`define POL_LIGHT 1'b0
`define OUTF_TRIGGER 4'h3
`define INF_TRIGGER 4'h1
// Reset values
`define RST_MASTER_CYCLE 16'h000a
`define RST_SLAVE_DELAY 16'h0000
`define RST_SCAN_LEN 16'h0064
`define RST_PIN_CFG 16'h0001
// Trigger pulse width in system cycles
`define TRIG_PULSE_CYCLES 8'h19
`endif

/* inc/cascade_trigger_sync_pkg.sv */
// Purpose: types of the cascade trigger block
// Assumes: nothing
// Notes: state codes written out
package cascade_trigger_sync_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_SCAN = 2'b10
  } slave_state_e;
endpackage

/* logic/cascade_trigger_sync.sv */
// Purpose: cascade trigger master and slave timing of a light curtain
// Assumes: inputs synchronous to sys_clk_i, plain register port
// Notes: one scan start pulse per accepted trigger
`timescale 1ns/100ps
`include "cascade_trigger_sync_consts.svh"

module cascade_trigger_sync
  import cascade_trigger_sync_pkg::*;
#(
  parameter int VAL_W = 16,       // Width of time settings
  parameter int US_DIV = `US_CYCLES  // System cycles per microsecond
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic scan_start_o,
  output logic scanning_o
);

  ////////////////////////////////////////////////////////////////////////
  // Register file
  logic [15:0] cascade; // Enable and role
  logic [VAL_W-1:0] master_cycle; // Period in ms
  logic [VAL_W-1:0] slave_delay; // Delay in us
  logic [15:0] pin_cfg; // Direction, polarity, functions
  logic [VAL_W-1:0] scan_len; // Scan length in us
  logic [15:0] next_rdata;
  logic [15:0] status_word;
  logic [15:0] next_cascade, next_pin_cfg;
  logic [VAL_W-1:0] next_master_cycle, next_slave_delay, next_scan_len;

  // Decoded settings
  logic en, is_master, dir_in, pol_light, out_trig, in_trig;
  assign en = (cascade[`FLD_ENABLE] == `ENABLE_ON);
  assign is_master = en && (cascade[`FLD_ROLE] == `ROLE_MASTER);
  assign dir_in = (pin_cfg[`FLD_DIR] == `DIR_INPUT);
  assign pol_light = (pin_cfg[`FLD_POL] == `POL_LIGHT);
  assign out_trig = (pin_cfg[`FLD_OUTF_LO+:4] == `OUTF_TRIGGER);
  assign in_trig = (pin_cfg[`FLD_INF_LO+:4] == `INF_TRIGGER);

  // Write decode and read mux
  always_comb begin
    next_cascade = cascade;
    next_master_cycle = master_cycle;
    next_slave_delay = slave_delay;
    next_pin_cfg = pin_cfg;
    next_scan_len = scan_len;
    next_rdata = 16'h0000;
    if (wr_i) begin
      unique case (addr_i)
        `REG_CASCADE: next_cascade = {14'h0000, wdata_i[1:0]};
        `REG_MASTER_CYCLE: next_master_cycle = wdata_i[VAL_W-1:0];
        `REG_SLAVE_DELAY: next_slave_delay = wdata_i[VAL_W-1:0];
        `REG_PIN_CFG: next_pin_cfg = {4'h0, wdata_i[11:0]};
        `REG_SCAN_LEN: next_scan_len = wdata_i[VAL_W-1:0];
        default: ; // Unmapped writes are dropped
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        `REG_CASCADE: next_rdata = cascade;
        `REG_MASTER_CYCLE: next_rdata = 16'(master_cycle);
        `REG_SLAVE_DELAY: next_rdata = 16'(slave_delay);
        `REG_PIN_CFG: next_rdata = pin_cfg;
        `REG_STATUS: next_rdata = status_word;
        `REG_SCAN_LEN: next_rdata = 16'(scan_len);
        default: next_rdata = 16'h0000; // Unmapped reads as zero
      endcase
    end
  end

  // Register storage
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cascade <= 16'h0000;
      master_cycle <= VAL_W'(`RST_MASTER_CYCLE);
      slave_delay <= VAL_W'(`RST_SLAVE_DELAY);
      pin_cfg <= `RST_PIN_CFG;
      scan_len <= VAL_W'(`RST_SCAN_LEN);
      rdata_o <= 16'h0000;
    end else begin
      cascade <= next_cascade;
      master_cycle <= next_master_cycle;
      slave_delay <= next_slave_delay;
      pin_cfg <= next_pin_cfg;
      scan_len <= next_scan_len;
      rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Microsecond tick divider
  logic [7:0] us_cnt, next_us_cnt;
  logic us_tick;
  assign us_tick = (us_cnt == 8'(US_DIV - 1));

  always_comb begin
    next_us_cnt = us_tick ? 8'h00 : us_cnt + 8'h01;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) us_cnt <= 8'h00;
    else us_cnt <= next_us_cnt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Master period generator, counted in microseconds
  logic [31:0] per_cnt, next_per_cnt;
  logic [31:0] period_us;
  logic [7:0] pulse_cnt, next_pulse_cnt;
  logic master_fire;
  logic cycle_wr; // Software writes a new cycle time
  // New cycle time restarts the count so it never overruns the period
  assign cycle_wr = wr_i && (addr_i == `REG_MASTER_CYCLE);
  // Zero period treated as 1 ms so the pin never sticks
  assign period_us = (master_cycle == '0) ? 32'(`MS_TO_US) :
                     32'(master_cycle) * 32'(`MS_TO_US);
  assign master_fire = is_master && us_tick &&
                       (per_cnt >= period_us - 32'h1);

  // Period count and trigger pulse stretch
  always_comb begin
    next_per_cnt = per_cnt;
    next_pulse_cnt = pulse_cnt;
    if (!is_master || cycle_wr) begin
      next_per_cnt = 32'h0; // Restart on role entry or new cycle time
    end else if (us_tick) begin
      next_per_cnt = master_fire ? 32'h0 : per_cnt + 32'h1;
    end
    if (master_fire) next_pulse_cnt = `TRIG_PULSE_CYCLES;
    else if (pulse_cnt != 8'h00) next_pulse_cnt = pulse_cnt - 8'h01;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      per_cnt <= 32'h0;
      pulse_cnt <= 8'h00;
    end else begin
      per_cnt <= next_per_cnt;
      pulse_cnt <= next_pulse_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive: master outputs when direction is output and output function is trigger
  logic trig_level;
  assign trig_level = (pulse_cnt != 8'h00);
  // Light switching: active high; otherwise inverted
  assign pin_o = pol_light ? trig_level : !trig_level;
  // Slave or input direction never drives the shared line
  assign pin_oe_o = is_master && !dir_in && out_trig;

  ////////////////////////////////////////////////////////////////////////
  // Slave edge detect and timing
  logic pin_prev, next_pin_prev;
  logic pin_act, trig_edge;
  logic is_slave;
  slave_state_e state, next_state;
  logic [VAL_W-1:0] tcnt, next_tcnt;
  logic next_scan_start;
  assign is_slave = en && (cascade[`FLD_ROLE] == `ROLE_SLAVE);
  assign pin_act = pol_light ? pin_i : !pin_i;
  assign trig_edge = pin_act && !pin_prev;
  assign next_pin_prev = pin_act;

  // Slave sequence: idle, delay, scan
  always_comb begin
    next_state = state;
    next_tcnt = tcnt;
    next_scan_start = 1'b0;
    unique case (state)
      ST_IDLE: begin
        // Only an input pin with trigger function is heard
        if (is_slave && dir_in && in_trig && trig_edge) begin
          next_tcnt = '0;
          if (slave_delay == '0) begin
            next_state = ST_SCAN;
            next_scan_start = 1'b1;
          end else begin
            next_state = ST_DELAY;
          end
        end
      end
      ST_DELAY: begin
        // Further edges ignored here
        if (!is_slave) next_state = ST_IDLE;
        else if (us_tick) begin
          if (tcnt == slave_delay - VAL_W'(1)) begin
            next_state = ST_SCAN;
            next_tcnt = '0;
            next_scan_start = 1'b1;
          end else begin
            next_tcnt = tcnt + VAL_W'(1);
          end
        end
      end
      ST_SCAN: begin
        // Scan window, edges ignored
        if (!is_slave) next_state = ST_IDLE;
        else if (us_tick) begin
          if (tcnt >= scan_len - VAL_W'(1) || scan_len == '0) begin
            next_state = ST_IDLE;
            next_tcnt = '0;
          end else begin
            next_tcnt = tcnt + VAL_W'(1);
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      tcnt <= '0;
      pin_prev <= 1'b1; // Avoids a false edge after reset
      scan_start_o <= 1'b0;
    end else begin
      state <= next_state;
      tcnt <= next_tcnt;
      pin_prev <= next_pin_prev;
      scan_start_o <= next_scan_start;
    end
  end

  assign scanning_o = (state == ST_SCAN);
  assign status_word = {10'h000, trig_level, scanning_o,
                        state == ST_DELAY, is_slave, is_master, en};

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_disabled_quiet;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      // Start pulse is registered, so it is checked one cycle on
      !en |-> !pin_oe_o ##1 !scan_start_o;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("Cascade active while disabled");

  property p_master_fires_pulse;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      master_fire |=> trig_level [*8];
  endproperty
  a_master_fires_pulse: assert property (p_master_fires_pulse)
    else $error("Master trigger pulse missing");

  property p_slave_no_drive;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (is_slave || dir_in) |-> !pin_oe_o;
  endproperty
  a_slave_no_drive: assert property (p_slave_no_drive)
    else $error("Slave drives shared pin");

  property p_master_drive;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (is_master && !dir_in && out_trig) |-> pin_oe_o;
  endproperty
  a_master_drive: assert property (p_master_drive)
    else $error("Master not driving pin");

  property p_out_func;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      !out_trig |-> !pin_oe_o;
  endproperty
  a_out_func: assert property (p_out_func)
    else $error("Pin driven without trigger function");

  property p_period_bound;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      is_master |-> per_cnt < period_us;
  endproperty
  a_period_bound: assert property (p_period_bound)
    else $error("Master period overrun");

  property p_delay_start;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state == ST_DELAY && us_tick && is_slave &&
       tcnt == slave_delay - VAL_W'(1)) |=> scan_start_o && scanning_o;
  endproperty
  a_delay_start: assert property (p_delay_start)
    else $error("Scan not started after delay");

  property p_one_scan;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      scan_start_o |-> $past(state) != ST_SCAN;
  endproperty
  a_one_scan: assert property (p_one_scan)
    else $error("Retrigger during scan");

  property p_slave_idle_trig;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state == ST_IDLE && !(is_slave && in_trig)) |=> state == ST_IDLE;
  endproperty
  a_slave_idle_trig: assert property (p_slave_idle_trig)
    else $error("Slave left idle without trigger");

  c_master: cover property (@(posedge sys_clk_i) master_fire);
  c_delay: cover property (@(posedge sys_clk_i) state == ST_DELAY);
  c_scan: cover property (@(posedge sys_clk_i) scan_start_o);

endmodule // cascade_trigger_sync

/* sim/test_cascade_trigger_sync.sv */
// Purpose: self-checking bench of the cascade trigger block
// Assumes: microsecond shortened to DIV clocks
// Notes: a model curtain drives the shared line in the slave tests
`timescale 1ns/100ps

module test_cascade_trigger_sync;
  import cascade_trigger_sync_pkg::*;
  localparam int DIV = 2;  // Clocks per microsecond, shortened
  localparam int LIMIT = 30000;  // Cycle ceiling, run needs ~13000
  typedef struct packed {
    logic [3:0] a;
    logic [15:0] v;
  } row_s;
  // Reset read-back: address beside expected word, one unmapped
  row_s rows [7] = '{'{4'h0, 16'h0000}, '{4'h1, 16'h000a},
    '{4'h2, 16'h0000}, '{4'h3, 16'h0001}, '{4'h4, 16'h0000},
    '{4'h5, 16'h0064}, '{4'hf, 16'h0000}};
  // Slave delays in us: first takes the zero-delay path, the rest pass through the delay state
  int dl [4] = '{0, 3, 7, 10};
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic fire = 1'b0;  // Model trigger request
  logic [15:0] rdata_o;
  logic [15:0] rv;  // Last read word
  logic pin_o, pin_oe_o, scan_start_o, scanning_o, line, pin, ok;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int n, m, c;

  ////////////////////////////////////////////////////////////////////////
  // Shared wire: our drive wins while enabled, else the model's
  assign pin = pin_oe_o ? pin_o : line;
  always #20 sys_clk_i = ~sys_clk_i;

  cascade_trigger_sync #(.US_DIV(DIV)) u_cascade_trigger_sync (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pin_i(pin), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .scan_start_o(scan_start_o), .scanning_o(scanning_o));
  trigger_line_model u_trigger_line_model (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .fire_i(fire), .line_o(line));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  // Read word stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    d = rdata_o;
  endtask

  task automatic fire_line();
    @(posedge sys_clk_i);
    fire <= 1'b1;
    @(posedge sys_clk_i);
    fire <= 1'b0;
  endtask

  function automatic logic probe(input int k);
    case (k)
      0: return pin_o;
      1: return scan_start_o;
      default: return scanning_o;
    endcase
  endfunction

  // Bounded wait, sampled mid-cycle where outputs are settled
  task automatic wait_for(input int k, input logic v, input int lim,
                          output int cnt);
    cnt = 0;
    @(negedge sys_clk_i);
    while (probe(k) !== v && cnt < lim) begin
      @(negedge sys_clk_i);
      cnt++;
    end
  endtask

  task automatic count_hi(input int k, input int span, output int cnt);
    cnt = 0;
    repeat (span) begin
      @(negedge sys_clk_i);
      if (probe(k) === 1'b1) begin
        cnt++;
      end
    end
  endtask

  // Hang guard
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check(16'({pin_oe_o, pin_o, scan_start_o}), 16'h0000);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].a, rv);
      check(rv, rows[i].v);
    end
    $display("test reset done");
    // Master, 2 ms period, trigger output
    wr(4'h0, 16'h0003);
    wr(4'h1, 16'h0002);
    wr(4'h3, 16'h0030);
    rd(4'h4, rv);
    check(rv & 16'h0007, 16'h0003);
    check(16'(pin_oe_o), 16'h0001);
    wait_for(0, 1'b1, 4100, n);
    check(16'(n < 4100), 16'h0001);
    wait_for(0, 1'b0, 40, n);
    check(16'(n + 1), 16'h0019);
    wait_for(0, 1'b1, 4100, n);
    check(16'(n + 26), 16'(2000 * DIV));
    wr(4'h3, 16'h0020);
    @(negedge sys_clk_i);
    check(16'(pin_oe_o), 16'h0000);
    // Input direction keeps even a master off the line
    wr(4'h3, 16'h0031);
    @(negedge sys_clk_i);
    check(16'(pin_oe_o), 16'h0000);
    wr(4'h3, 16'h0030);
    wr(4'h0, 16'h0002);
    // Let the running pulse finish before watching for silence
    repeat (30) @(posedge sys_clk_i);
    wait_for(0, 1'b1, 4100, n);
    check(16'(n == 4100), 16'h0001);
    // Dark switching idles the pin high
    wr(4'h3, 16'h0032);
    @(negedge sys_clk_i);
    check(16'(pin_o), 16'h0001);
    $display("test master done");
    // Slave, 5 us scan, trigger input
    wr(4'h0, 16'h0001);
    wr(4'h5, 16'h0005);
    wr(4'h3, 16'h0101);
    rd(4'h4, rv);
    check(rv & 16'h0007, 16'h0005);
    check(16'(pin_oe_o), 16'h0000);
    foreach (dl[i]) begin
      wr(4'h2, 16'(dl[i]));
      fire_line();
      wait_for(1, 1'b1, 200, n);
      ok = n >= (dl[i] - 1) * DIV && n <= dl[i] * DIV + DIV + 3;
      check(16'(ok), 16'h0001);
      wait_for(2, 1'b0, 100, m);
      check(16'(m >= 4 * DIV && m <= 6 * DIV), 16'h0001);
      repeat (30) @(posedge sys_clk_i);
    end
    // Second trigger lands in the delay
    wr(4'h2, 16'h0014);
    fire_line();
    repeat (30) @(posedge sys_clk_i);
    fire_line();
    count_hi(1, 150, c);
    check(16'(c), 16'h0001);
    wr(4'h0, 16'h0000);
    fire_line();
    count_hi(1, 80, c);
    check(16'(c), 16'h0000);
    wr(4'h0, 16'h0001);
    wr(4'h3, 16'h0001);
    fire_line();
    count_hi(1, 80, c);
    check(16'(c), 16'h0000);
    $display("test slave done");
    report_and_stop();
  end
endmodule // test_cascade_trigger_sync

/* sim/trigger_line_model.sv */
// Purpose: other curtain acting as cascade master on the shared line
// Assumes: bench raises fire_i for one cycle per trigger
// Notes: line is driven low between pulses, so it never floats
`timescale 1ns/100ps

module trigger_line_model #(
  parameter int PULSE = 25  // Pulse width in clocks
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic fire_i,
  output logic line_o
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] left;  // Clocks of pulse still to go
  logic [7:0] next_left;  // Next pulse count

  // Load on a fire request, count down otherwise
  always_comb begin
    next_left = left;
    if (fire_i) begin
      next_left = 8'(PULSE);
    end else if (left != 8'h00) begin
      next_left = left - 8'h01;
    end
  end

  // Register only
  always_ff @(posedge sys_clk_i) begin
    left <= rst_n_i ? next_left : 8'h00;
  end

  // High means trigger: light-switching polarity
  assign line_o = (left != 8'h00);
endmodule // trigger_line_model
